/* bench/psc_ctrl_status_properties.sv */
// Concurrent checks on the ports of the control and status word block
`timescale 1ns/1ps
module psc_ctrl_status_properties
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Serial link
    input wire spi_cs_n_i,
    input wire spi_miso_o,
    input wire spi_miso_oe_n_o,
    // Fault inputs
    input wire temp_warn_i,
    input wire wdog_fault_i,
    // Controls and error pin
    input wire [5:0] tracker_enable_o,
    input wire [7:0] reset_delay_ms_o,
    input wire [7:0] window_len_ms_o,
    input wire wdog_enable_o,
    input wire wdog_kick_o,
    input wire err_n_o
);
    // One clock domain, so one default clock and reset for every check
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Kick is a single cycle, and only just after a frame has closed
    AST_KICK_ONE_CYCLE: assert property (wdog_kick_o |=> !wdog_kick_o)
        else $error("kick pulse longer than one cycle");
    AST_KICK_AFTER_CS_RISE: assert property (wdog_kick_o |-> spi_cs_n_i && $past(spi_cs_n_i, 3))
        else $error("kick outside a frame end");
    // Sync latency is 2 to 3 clocks, so six idle clocks leave ample margin
    AST_RELEASE_IDLE: assert property (spi_cs_n_i [*6] |-> spi_miso_oe_n_o)
        else $error("data output driven while deselected");
    AST_MISO_LOW_RELEASED: assert property (spi_miso_oe_n_o |-> !spi_miso_o)
        else $error("data output not low while released");
    AST_DRIVE_AFTER_CS_FALL: assert property ($fell(spi_cs_n_i) |-> ##[1:5] !spi_miso_oe_n_o)
        else $error("data output not driven after select");
    // Control outputs may only move once select is back high
    AST_CTRL_AT_FRAME_END: assert property ($changed({tracker_enable_o, wdog_enable_o})
        |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
        else $error("control output changed inside a frame");
    AST_TEMP_ERR_PIN: assert property (temp_warn_i [*6] |-> !err_n_o)
        else $error("error pin high during prewarning");
    AST_FAULT_ERR_PIN: assert property ($rose(wdog_fault_i) |-> ##[1:6] !err_n_o)
        else $error("error pin not low after watchdog fault");
    AST_FIELD_CODES: assert property (reset_delay_ms_o inside {8'h08, 8'h10, 8'h20, 8'h40}
        && window_len_ms_o inside {8'h10, 8'h20, 8'h40, 8'h80})
        else $error("delay or window length off the code table");
endmodule

bind psc_ctrl_status psc_ctrl_status_properties chk
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_miso_o(spi_miso_o),
    .spi_miso_oe_n_o(spi_miso_oe_n_o),
    .temp_warn_i(temp_warn_i),
    .wdog_fault_i(wdog_fault_i),
    .tracker_enable_o(tracker_enable_o),
    .reset_delay_ms_o(reset_delay_ms_o),
    .window_len_ms_o(window_len_ms_o),
    .wdog_enable_o(wdog_enable_o),
    .wdog_kick_o(wdog_kick_o),
    .err_n_o(err_n_o)
);

/* bench/psc_ctrl_status_tb.sv */
// Self-checking bench for the control and status word block
`timescale 1ns/1ps
module psc_ctrl_status_tb;
    reg clk_i, rst_i, temp, warm_a, warm_b, win, fault, buck;
    reg [5:0] settled;
    reg [2:0] rail, kb;
    reg [15:0] c, got_s;
    reg [7:0] kick_cnt, kick_ref;
    integer k, n_mismatch, cmp_count;
    wire sclk, cs_n, mosi, miso, oe_n, pn, wen, kick, err_n;
    wire [5:0] trk;
    wire [7:0] dly, wlen;
    // Released data line reads inverted, so a sample outside the driven span shows up
    wire miso_line = oe_n ? ~miso : miso;

    // Short settle count keeps the tracker check inside the run
    psc_ctrl_status #(.SETTLE_CYCLES(15'd20)) dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n), .temp_warn_i(temp), .tracker_settled_i(settled),
        .warm_start_a_i(warm_a), .warm_start_b_i(warm_b), .window_phase_i(win), .rail_reset_flag_i(rail),
        .wdog_fault_i(fault), .buck_on_flag_i(buck), .tracker_enable_o(trk), .power_normal_o(pn),
        .reset_delay_ms_o(dly), .window_len_ms_o(wlen), .wdog_enable_o(wen), .wdog_kick_o(kick),
        .err_n_o(err_n)
    );
    psc_spi_master master (.clk_i(clk_i), .spi_miso_i(miso_line), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
        .spi_mosi_o(mosi));

    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    task chk(input [15:0] got, input [15:0] exp, input [8*8:1] what);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0t %0s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask

    // Control outputs expected from a control word
    task outs(input [15:0] w);
        begin
            chk({10'h000, trk}, {10'h000, w[7:2]}, "trackers");
            chk({15'h0000, pn}, {15'h0000, w[8]}, "power");
            chk({8'h00, dly}, 16'h0040 >> w[11:10], "delay");
            chk({8'h00, wlen}, 16'h0080 >> w[13:12], "window");
            chk({15'h0000, wen}, {15'h0000, (!w[0] && w[9] && !w[14])}, "wdog en");
            chk({8'h00, kick_cnt}, {8'h00, kick_ref}, "kicks");
        end
    endtask

    task frame(input [15:0] w, input [15:0] exp);
        begin
            master.xfer(w, 16, got_s);
            chk(got_s, exp, "status");
            chk({14'h0000, oe_n, miso}, 16'h0002, "release");
            if (w[15])
                kick_ref = kick_ref + 8'h01;
            outs(w);
        end
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Count kick pulses as they happen
    always @(posedge clk_i)
        if (kick === 1'b1)
            kick_cnt <= kick_cnt + 8'h01;

    // Watchdog: the tests need about 2700 clocks
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch = n_mismatch + 1;
        final_report;
    end

    initial
    begin
        rst_i = 1'b1;
        temp = 1'b0;
        settled = 6'h3f;
        warm_a = 1'b1;
        warm_b = 1'b1;
        win = 1'b0;
        rail = 3'h0;
        fault = 1'b0;
        buck = 1'b1;
        n_mismatch = 0;
        cmp_count = 0;
        kick_cnt = 8'h00;
        kick_ref = 8'h00;
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (10) @(negedge clk_i);
        outs(16'h4dfd);
        chk({15'h0000, err_n}, 16'h0000, "err pin");
        frame(16'h4dfd, 16'h83fd);
        frame(16'h4dfd, 16'h83fc);
        chk({15'h0000, err_n}, 16'h0001, "err pin");
        // Every field code, every watchdog enable pattern, kick on and off
        for (k = 0; k < 8; k = k + 1)
        begin
            kb = k[2:0];
            c = {kb[0], kb[2], kb[2:1], kb[1:0], kb[1], kb != 3'd5, 6'h3f ^ {3'b000, kb}, 1'b0, kb[0]};
            frame(c, 16'h83fc);
        end
        // A short frame must leave everything as it was
        master.xfer(16'h0000, 12, got_s);
        outs(c);
        frame(16'h4dfd, 16'h83fc);
        temp = 1'b1;
        settled = 6'h2a;
        warm_a = 1'b0;
        win = 1'b1;
        rail = 3'h5;
        fault = 1'b1;
        buck = 1'b0;
        repeat (40) @(negedge clk_i);
        chk({15'h0000, err_n}, 16'h0000, "err pin");
        frame(16'h4dfd, 16'h6fab);
        temp = 1'b0;
        settled = 6'h3f;
        win = 1'b0;
        rail = 3'h0;
        fault = 1'b0;
        buck = 1'b1;
        repeat (10) @(negedge clk_i);
        frame(16'h4dfd, 16'hc2fd);
        warm_a = 1'b1;
        repeat (10) @(negedge clk_i);
        frame(16'h4dfd, 16'h83fd);
        frame(16'h4dfd, 16'h83fc);
        chk({15'h0000, err_n}, 16'h0001, "err pin");
        // Unsettled tracker alone raises the error; switched off it no longer counts
        settled = 6'h3e;
        repeat (10) @(negedge clk_i);
        chk({15'h0000, err_n}, 16'h0000, "err pin");
        frame(16'h4df9, 16'h83f9);
        frame(16'h4df9, 16'h83f9);
        chk({15'h0000, err_n}, 16'h0001, "err pin");
        // Reset in mid-run brings back the default control word and a cold start
        settled = 6'h3f;
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (10) @(negedge clk_i);
        outs(16'h4dfd);
        chk({15'h0000, err_n}, 16'h0000, "err pin");
        frame(16'h4dfd, 16'h83fd);
        chk({15'h0000, err_n}, 16'h0001, "err pin");
        final_report;
    end
endmodule

/* bench/psc_spi_master.sv */
// Serial master model that frames control words into the block
`timescale 1ns/1ps
module psc_spi_master
(
    // Clock used to pace the link
    input wire clk_i,
    // Serial link
    input wire spi_miso_i,
    output reg spi_sclk_o,
    output reg spi_cs_n_o,
    output reg spi_mosi_o
);
    // Idle: deselected, serial clock parked low between frames
    initial
    begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    // Half of the 320 ns link period is four system clocks
    task half;
        repeat (4) @(negedge clk_i);
    endtask

    // Frame of n bits, LSB first; status read late in the high phase, clear of the shift
    task xfer(input [15:0] w, input integer n, output [15:0] stat);
        integer i;
        begin
            stat = 16'h0000;
            spi_cs_n_o = 1'b0;
            for (i = 0; i < n; i = i + 1)
            begin
                spi_mosi_o = w[i];
                half;
                spi_sclk_o = 1'b1;
                half;
                stat[i] = spi_miso_i;
                spi_sclk_o = 1'b0;
            end
            half;
            spi_cs_n_o = 1'b1;
            spi_mosi_o = ~spi_mosi_o;
            repeat (8) @(negedge clk_i);
        end
    endtask
endmodule

/* hdl/psc_ctrl_status.v */
// Serial control word and diagnostic status word of the power supply
//
// Summary of operation
// R1: Control bits 2..7 switch trackers one to six; 1 is on, default on.
// R2: Control bit 8 at 0 requests sleep, at 1 normal; default 1.
// R3: Control bits 10,11 pick reset delay 64/32/16/8 ms; default 8 ms.
// R4: Control bits 12,13 pick window length 128/64/32/16 ms; default 128.
// R5: Watchdog enabled only for bits 0,9,14 equal 0,1,0; default disabled.
// R6: Control bit 15 at 1 marks a watchdog trigger; master sends 0 otherwise.
// R7: Status bit 0 is a latched error flag, default 0.
// R8: Status bit 1 shows overtemperature prewarning live.
// R9: Status bits 2..7 show each tracker settled live.
// R10: Status bit 8 latches warm start of first rail, default 0.
// R11: Status bit 9 latches warm start of second rail, default 0.
// R12: Status bit 10 shows live watchdog window, 1 in closed window.
// R13: Status bits 11..13 show live rail reset assertion.
// R14: Status bit 15 shows buck converter on live, default 1.
// R15: Error pin low and bit 0 set on warning, watchdog fault, cold start, settle fail.
// R16: Status defaults: trackers and converter at 1, all else 0.
// R17: Sixteen-bit frames, LSB first, status out while control shifts in.
// R18: Chip select rising loads control word and releases data output.
// R19: Both start-type flags clear after every completed frame unless their input still reads 1.
// R20: Watchdog trigger taken at chip select rise when trigger bit is 1.
// R21: Latched error and watchdog fault clear once shown, if cause gone.
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_ctrl_status
#(
    parameter [`PSC_SETTLE_CNT_W-1:0] SETTLE_CYCLES = `PSC_SETTLE_CYCLES
)
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Serial link from the microcontroller
    input wire spi_sclk_i,
    input wire spi_cs_n_i,
    input wire spi_mosi_i,
    output reg spi_miso_o,
    output reg spi_miso_oe_n_o,
    // Live analog and watchdog inputs
    input wire temp_warn_i,
    input wire [5:0] tracker_settled_i,
    input wire warm_start_a_i,
    input wire warm_start_b_i,
    input wire window_phase_i,
    input wire [2:0] rail_reset_flag_i,
    input wire wdog_fault_i,
    input wire buck_on_flag_i,
    // Controls to the regulators and watchdog
    output reg [5:0] tracker_enable_o,
    output reg power_normal_o,
    output reg [7:0] reset_delay_ms_o,
    output reg [7:0] window_len_ms_o,
    output reg wdog_enable_o,
    output reg wdog_kick_o,
    // Error pin, low on fault
    output reg err_n_o
);

// ----------------------------------------------------------------------------
// Decoding
// ----------------------------------------------------------------------------

// Field written low bit first: 00 full, 10 half, 01 quarter, 11 eighth
function [7:0] psc_len;
    input lo;
    input hi;
    input [7:0] full;
    begin
        case ({lo, hi})
            2'b00: psc_len = full;
            2'b10: psc_len = {1'b0, full[7:1]};
            2'b01: psc_len = {2'b00, full[7:2]};
            default: psc_len = {3'b000, full[7:3]};
        endcase
    end
endfunction

// ----------------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------------

wire sclk_s;
wire cs_n_s;
wire mosi_s;
wire [15:0] live_s;

// Link pins; chip select idles high so it resets high
psc_sync #(.W(3), .RST_VAL(3'b010)) u_sync_link
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({spi_sclk_i, spi_cs_n_i, spi_mosi_i}),
    .q_o({sclk_s, cs_n_s, mosi_s})
);

// Status sources, laid out in status word positions
psc_sync #(.W(16), .RST_VAL(`PSC_STATUS_RESET)) u_sync_live // R16
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({buck_on_flag_i, wdog_fault_i, rail_reset_flag_i, window_phase_i,
          warm_start_b_i, warm_start_a_i, tracker_settled_i, temp_warn_i, 1'b0}),
    .q_o(live_s)
);

// ----------------------------------------------------------------------------
// Link edge detection
// ----------------------------------------------------------------------------

reg sclk_d_ff;
reg cs_n_d_ff;

// Delayed copies of the synchronised link levels
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        sclk_d_ff <= 1'b0;
        cs_n_d_ff <= 1'b1;
    end
    else
    begin
        sclk_d_ff <= sclk_s;
        cs_n_d_ff <= cs_n_s;
    end
end

wire cs_fall = cs_n_d_ff & ~cs_n_s;
wire cs_rise = ~cs_n_d_ff & cs_n_s;
wire sclk_rise = ~cs_n_s & ~sclk_d_ff & sclk_s;
wire sclk_fall = ~cs_n_s & sclk_d_ff & ~sclk_s;

// ----------------------------------------------------------------------------
// Control word and frame shifter
// ----------------------------------------------------------------------------

reg [15:0] ctrl_ff;
reg [15:0] rx_ff;
reg [15:0] tx_ff;
reg [15:0] shown_ff;
reg [`PSC_CNT_W-1:0] cnt_ff;
reg frame_ok_ff;
reg warm_a_ff;
reg warm_b_ff;
reg fault_ff;
reg error_ff;

wire frame_done = cs_rise & (cnt_ff == `PSC_FRAME_BITS);
wire settle_fail;

// Error causes; cold start means a start flag still reads 0
wire err_cause = live_s[`PSC_S_TEMP] | fault_ff | ~warm_a_ff | ~warm_b_ff | settle_fail; // R15

// Status word as presented at chip select fall
wire [15:0] status_w = {live_s[`PSC_S_BUCK_ON], // R14
                        fault_ff,
                        live_s[`PSC_S_RAIL_RST_HI:`PSC_S_RAIL_RST_LO], // R13
                        live_s[`PSC_S_WIN_PHASE], // R12
                        warm_b_ff,
                        warm_a_ff,
                        live_s[`PSC_S_TRK_HI:`PSC_S_TRK_LO], // R9
                        live_s[`PSC_S_TEMP], // R8
                        error_ff};

// Shift in on serial clock rise, out on fall, LSB first
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        rx_ff <= 16'h0000;
        tx_ff <= 16'h0000;
        shown_ff <= 16'h0000;
        cnt_ff <= {`PSC_CNT_W{1'b0}};
        spi_miso_o <= 1'b0;
        spi_miso_oe_n_o <= 1'b1;
    end
    else if (cs_fall)
    begin
        tx_ff <= {1'b0, status_w[15:1]}; // R17
        shown_ff <= status_w;
        spi_miso_o <= status_w[0]; // R17
        spi_miso_oe_n_o <= 1'b0;
        cnt_ff <= {`PSC_CNT_W{1'b0}};
    end
    else if (cs_rise)
    begin
        spi_miso_oe_n_o <= 1'b1; // R18
        spi_miso_o <= 1'b0;
    end
    else
    begin
        if (sclk_rise)
        begin
            rx_ff <= {mosi_s, rx_ff[15:1]}; // R17
            // Count saturates past a full word so long frames are refused
            if (cnt_ff != `PSC_FRAME_BITS + 5'd1)
            begin
                cnt_ff <= cnt_ff + 5'd1;
            end
        end
        if (sclk_fall)
        begin
            spi_miso_o <= tx_ff[0]; // R17
            tx_ff <= {1'b0, tx_ff[15:1]};
        end
    end
end

// Only a complete sixteen-bit frame replaces the control word
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        ctrl_ff <= `PSC_CTRL_RESET;
        frame_ok_ff <= 1'b0;
    end
    else
    begin
        frame_ok_ff <= frame_done;
        if (frame_done)
        begin
            ctrl_ff <= rx_ff; // R18
        end
    end
end

// ----------------------------------------------------------------------------
// Latched status flags
// ----------------------------------------------------------------------------

// Set wins over the end-of-frame clear so no event is lost
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        warm_a_ff <= 1'b0;
        warm_b_ff <= 1'b0;
        fault_ff <= 1'b0;
        error_ff <= 1'b0;
    end
    else
    begin
        if (live_s[`PSC_S_WARM_A])
        begin
            warm_a_ff <= 1'b1; // R10
        end
        else if (frame_done)
        begin
            warm_a_ff <= 1'b0; // R19
        end
        if (live_s[`PSC_S_WARM_B])
        begin
            warm_b_ff <= 1'b1; // R11
        end
        else if (frame_done)
        begin
            warm_b_ff <= 1'b0; // R19
        end
        if (live_s[`PSC_S_WDOG_FAULT])
        begin
            fault_ff <= 1'b1;
        end
        else if (frame_done && shown_ff[`PSC_S_WDOG_FAULT])
        begin
            fault_ff <= 1'b0; // R21
        end
        if (err_cause)
        begin
            error_ff <= 1'b1; // R7
        end
        else if (frame_done && shown_ff[`PSC_S_ERROR])
        begin
            error_ff <= 1'b0; // R21
        end
    end
end

// ----------------------------------------------------------------------------
// Tracker settle supervision
// ----------------------------------------------------------------------------

// Driven from the registered enables so the timer sees what the pins see
psc_settle #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_settle
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(tracker_enable_o),
    .settled_i(live_s[`PSC_S_TRK_HI:`PSC_S_TRK_LO]),
    .fail_o(settle_fail)
);

// ----------------------------------------------------------------------------
// Control outputs
// ----------------------------------------------------------------------------

// All outputs registered; all but err_n_o follow the control word one cycle later
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        tracker_enable_o <= 6'h3f;
        power_normal_o <= 1'b1;
        reset_delay_ms_o <= 8'h08;
        window_len_ms_o <= `PSC_WIN_LEN_MAX_MS;
        wdog_enable_o <= 1'b0;
        wdog_kick_o <= 1'b0;
        err_n_o <= 1'b1;
    end
    else
    begin
        tracker_enable_o <= ctrl_ff[`PSC_C_TRK_HI:`PSC_C_TRK_LO]; // R1
        power_normal_o <= ctrl_ff[`PSC_C_NORMAL]; // R2
        reset_delay_ms_o <= psc_len(ctrl_ff[`PSC_C_RST_DLY_LO], ctrl_ff[`PSC_C_RST_DLY_HI],
                                    `PSC_RST_DLY_MAX_MS); // R3
        window_len_ms_o <= psc_len(ctrl_ff[`PSC_C_WIN_LEN_LO], ctrl_ff[`PSC_C_WIN_LEN_HI],
                                   `PSC_WIN_LEN_MAX_MS); // R4
        wdog_enable_o <= ~ctrl_ff[`PSC_C_WDOG_DIS_A] & ctrl_ff[`PSC_C_WDOG_DIS_B]
                         & ~ctrl_ff[`PSC_C_WDOG_DIS_C]; // R5
        // One pulse per complete frame that carries the trigger bit
        wdog_kick_o <= frame_ok_ff & ctrl_ff[`PSC_C_WDOG_KICK]; // R6 R20
        err_n_o <= ~error_ff; // R15
    end
end

endmodule

/* hdl/psc_defines.vh */
// Constants of the power supply control and status word block
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// ----------------------------------------------------------------------------
// Frame format
// ----------------------------------------------------------------------------
`define PSC_FRAME_BITS 5'd16
`define PSC_CNT_W 5

// ----------------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------------
`define PSC_C_WDOG_DIS_A 0
`define PSC_C_TRK_LO 2
`define PSC_C_TRK_HI 7
`define PSC_C_NORMAL 8
`define PSC_C_WDOG_DIS_B 9
`define PSC_C_RST_DLY_LO 10
`define PSC_C_RST_DLY_HI 11
`define PSC_C_WIN_LEN_LO 12
`define PSC_C_WIN_LEN_HI 13
`define PSC_C_WDOG_DIS_C 14
`define PSC_C_WDOG_KICK 15
`define PSC_CTRL_RESET 16'h4dfd

// ----------------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------------
`define PSC_S_ERROR 0
`define PSC_S_TEMP 1
`define PSC_S_TRK_LO 2
`define PSC_S_TRK_HI 7
`define PSC_S_WARM_A 8
`define PSC_S_WARM_B 9
`define PSC_S_WIN_PHASE 10
`define PSC_S_RAIL_RST_LO 11
`define PSC_S_RAIL_RST_HI 13
`define PSC_S_WDOG_FAULT 14
`define PSC_S_BUCK_ON 15
`define PSC_STATUS_RESET 16'h80fc

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PSC_RST_DLY_MAX_MS 8'h40
`define PSC_WIN_LEN_MAX_MS 8'h80
// Settle limit of 1000 us at 25 MHz, sized to the timer width
`define PSC_SETTLE_CYCLES 15'd25000
`define PSC_SETTLE_CNT_W 15

`endif

/* hdl/psc_settle.v */
// Per-tracker settle timers that flag a tracker not settled in time
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_settle
#(
    parameter [`PSC_SETTLE_CNT_W-1:0] SETTLE_CYCLES = `PSC_SETTLE_CYCLES
)
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Tracker state
    input wire [5:0] enable_i,
    input wire [5:0] settled_i,
    // Result
    output wire fail_o
);

wire [5:0] fail_w;

genvar g;
generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_trk
        reg [`PSC_SETTLE_CNT_W-1:0] cnt_ff;
        reg expired_ff;
        // Timer restarts whenever the tracker is switched off
        always @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                cnt_ff <= {`PSC_SETTLE_CNT_W{1'b0}};
                expired_ff <= 1'b0;
            end
            else if (!enable_i[g])
            begin
                cnt_ff <= {`PSC_SETTLE_CNT_W{1'b0}};
                expired_ff <= 1'b0;
            end
            else if (!expired_ff)
            begin
                cnt_ff <= cnt_ff + 1'b1;
                expired_ff <= (cnt_ff == SETTLE_CYCLES - 1'b1);
            end
        end
        // Also catches a later short once the settle time has run
        assign fail_w[g] = enable_i[g] & expired_ff & ~settled_i[g]; // R15
    end
endgenerate

assign fail_o = |fail_w;

endmodule

/* hdl/psc_sync.v */
// Two flip-flop synchroniser for levels entering the clk_i domain
`timescale 1ns/1ps
module psc_sync
#(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Levels
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);

reg [W-1:0] meta_ff;

// First stage feeds only the second stage
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        meta_ff <= RST_VAL;
        q_o <= RST_VAL;
    end
    else
    begin
        meta_ff <= d_i;
        q_o <= meta_ff;
    end
end

endmodule
